// [src/adc_readout_pkg.sv]
// Purpose: shared constants and carriers for the dual converter serial readout
// Assumes: serial pins are sampled by the 40 MHz system clock
// Notes: edge numbers count serial clock falling edges within one 32-cycle group
`default_nettype none
package adc_readout_pkg;
  localparam int RESULT_W = 12;
  localparam int CNT_W = 6;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_SYS_HZ = 40000000;
  // ***************************************
  // falling edge numbers within one group
  // ***************************************
  localparam logic [CNT_W-1:0] EDGE_NONE = 6'h00;
  localparam logic [CNT_W-1:0] EDGE_FIRST = 6'h01;
  localparam logic [CNT_W-1:0] EDGE_CONVERT = 6'h04;
  localparam logic [CNT_W-1:0] EDGE_A_FIRST = 6'h05;
  localparam logic [CNT_W-1:0] EDGE_A_LAST = 6'h10;
  localparam logic [CNT_W-1:0] EDGE_B_FIRST = 6'h15;
  localparam logic [CNT_W-1:0] EDGE_B_LAST = 6'h20;
  // ***************************************
  // reset values
  // ***************************************
  localparam logic CS_N_RESET = 1'b1;
  localparam logic SCLK_RESET = 1'b0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

  typedef enum logic [2:0] {
    st_off,
    st_arm,
    st_track,
    st_convert,
    st_rest
  } seq_state_t;

  typedef struct packed {
    logic track_phase;
    logic convert_phase;
    logic power_down;
  } phase_t;

  typedef struct packed {
    logic [RESULT_W-1:0] chan_a;
    logic [RESULT_W-1:0] chan_b;
  } sample_pair_t;
endpackage : adc_readout_pkg
`default_nettype wire

// [src/dual_adc_serial_readout.sv]
// Purpose: serial readout and conversion sequencer of a dual 12-bit converter
// Assumes: host drives frame select and serial clock; results arrive on sample_in
// Notes: serial clock is oversampled, so every pin action lags by a few system cycles
`default_nettype none
module dual_adc_serial_readout
  import adc_readout_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire sample_pair_t sample_in,
  output logic dout_out,
  output logic dout_oe_n_out,
  output phase_t phase_out
);
  // ***************************************
  // pin sampling
  // ***************************************
  logic [1:0] pins_sync;
  logic cs_n_s;
  logic sclk_s;
  logic cs_n_prev;
  logic sclk_prev;
  logic cs_fall;
  logic sclk_fall;
  seq_state_t state;
  seq_state_t next_state;
  logic [CNT_W-1:0] edge_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic edge_hit;
  sample_pair_t held;

  pin_sync #(
    .WIDTH(2),
    .RESET_VAL({CS_N_RESET, SCLK_RESET})
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .pin_in({cs_n_in, sclk_in}),
    .sync_out(pins_sync)
  );

  assign cs_n_s = pins_sync[1];
  assign sclk_s = pins_sync[0];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_n_prev <= CS_N_RESET;
      sclk_prev <= SCLK_RESET;
    end else begin
      cs_n_prev <= cs_n_s;
      sclk_prev <= sclk_s;
    end
  end

  assign cs_fall = cs_n_prev && !cs_n_s;
  assign sclk_fall = sclk_prev && !sclk_s;

  // ***************************************
  // decoding helpers
  // ***************************************
  function automatic seq_state_t phase_of(input logic [CNT_W-1:0] n);
    if (n < EDGE_CONVERT) begin
      phase_of = st_track;
    end else if (n < EDGE_A_LAST) begin
      phase_of = st_convert;
    end else begin
      phase_of = st_rest;
    end
  endfunction : phase_of

  function automatic logic bit_for(input logic [CNT_W-1:0] n, input sample_pair_t s);
    logic [CNT_W-1:0] ia;
    logic [CNT_W-1:0] ib;
    ia = EDGE_A_LAST - n;
    ib = EDGE_B_LAST - n;
    if (n >= EDGE_A_FIRST && n <= EDGE_A_LAST) begin
      bit_for = s.chan_a[ia[3:0]];
    end else if (n >= EDGE_B_FIRST && n <= EDGE_B_LAST) begin
      bit_for = s.chan_b[ib[3:0]];
    end else begin
      bit_for = 1'b0;
    end
  endfunction : bit_for

  // ***************************************
  // sequencer
  // ***************************************
  always_comb begin
    next_state = state;
    next_cnt = edge_cnt;
    edge_hit = 1'b0;
    if (cs_n_s) begin
      next_state = st_off;
      next_cnt = EDGE_NONE;
    end else if (cs_fall) begin
      if (!sclk_s) begin
        next_state = st_track;
        next_cnt = EDGE_FIRST;
        edge_hit = 1'b1;
      end else begin
        next_state = st_arm;
        next_cnt = EDGE_NONE;
      end
    end else if (sclk_fall && state != st_off) begin
      if (state == st_arm || edge_cnt == EDGE_B_LAST) begin
        next_cnt = EDGE_FIRST;
      end else begin
        next_cnt = edge_cnt + 6'h01;
      end
      next_state = phase_of(next_cnt);
      edge_hit = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= st_off;
      edge_cnt <= EDGE_NONE;
    end else begin
      state <= next_state;
      edge_cnt <= next_cnt;
    end
  end

  // sampled at the start of conversion so the bits match this group
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held <= '{chan_a: RESULT_RESET, chan_b: RESULT_RESET};
    end else if (edge_hit && next_cnt == EDGE_CONVERT) begin
      held <= sample_in;
    end
  end

  // ***************************************
  // serial output
  // ***************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_out <= 1'b0;
      dout_oe_n_out <= 1'b1;
    end else if (cs_n_s) begin
      dout_out <= 1'b0;
      dout_oe_n_out <= 1'b1;
    end else begin
      dout_oe_n_out <= 1'b0;
      if (cs_fall) begin
        dout_out <= 1'b0;
      end else if (edge_hit) begin
        dout_out <= bit_for(next_cnt, held);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_out <= '{track_phase: 1'b0, convert_phase: 1'b0, power_down: 1'b1};
    end else begin
      phase_out.track_phase <= (next_state == st_track);
      phase_out.convert_phase <= (next_state == st_convert);
      phase_out.power_down <= (next_state == st_off || next_state == st_rest
                               || next_state == st_arm);
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_FLOAT_ON_RISE: assert property ($rose(cs_n_s) |=> dout_oe_n_out && !dout_out)
    else $error("output not floated after frame select rise");
  AST_DRIVE_IN_FRAME: assert property (!cs_n_s |=> !dout_oe_n_out)
    else $error("output not driven inside frame");
  AST_START_CLK_LOW: assert property (cs_fall && !sclk_s
    |=> edge_cnt == EDGE_FIRST && state == st_track)
    else $error("frame start with clock low did not count first edge");
  AST_START_CLK_HIGH: assert property (cs_fall && sclk_s
    |=> state == st_arm && edge_cnt == EDGE_NONE && phase_out.power_down)
    else $error("frame start with clock high did not wait");
  AST_LEAD_ZEROS: assert property (!cs_n_s && edge_hit
    && next_cnt < EDGE_A_FIRST |=> !dout_out)
    else $error("leading bit not zero");
  AST_MSB_A: assert property (!cs_n_s && sclk_fall && edge_cnt == EDGE_CONVERT
    && state == st_convert |=> dout_out == $past(held.chan_a[RESULT_W-1]))
    else $error("channel A MSB wrong on fifth edge");
  AST_GROUP_WRAP: assert property (!cs_n_s && !cs_fall && sclk_fall
    && edge_cnt == EDGE_B_LAST |=> edge_cnt == EDGE_FIRST && state == st_track)
    else $error("continuous group did not restart tracking");
  AST_CONVERT_AT_4: assert property (!cs_n_s && !cs_fall && sclk_fall
    && edge_cnt == 6'h03 && state == st_track
    |=> state == st_convert && phase_out.convert_phase)
    else $error("conversion did not begin on fourth edge");
  AST_REST_AT_16: assert property (!cs_n_s && !cs_fall && sclk_fall
    && edge_cnt == 6'h0F |=> state == st_rest)
    else $error("no power-down after conversion");
  AST_ABORT: assert property ($rose(cs_n_s) |=> edge_cnt == EDGE_NONE
    && state == st_off && phase_out.power_down)
    else $error("frame select rise did not end frame");

  COV_SINGLE: cover property (edge_cnt == EDGE_B_LAST ##[1:20] $rose(cs_n_s));
  COV_CONTINUOUS: cover property (edge_cnt == EDGE_B_LAST ##[1:20] edge_cnt == EDGE_FIRST);
  COV_ABORT: cover property (state == st_convert ##1 $rose(cs_n_s));
  COV_ARM: cover property (state == st_arm ##[1:20] state == st_track);
endmodule : dual_adc_serial_readout
`default_nettype wire

// [src/pin_sync.sv]
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels relative to clk_sys_in
// Notes: only the last stage leaves this module
`default_nettype none
module pin_sync
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= pin_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [tb/host_model.sv]
// Purpose: serial master model that frames conversions and shifts results in
// Assumes: driven from the 40 MHz bench clock, serial clock period of 8 cycles
// Notes: a floating result line reads as the inverse of the last bit seen
`default_nettype none
module host_model
  import adc_readout_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic dout_in,
  input wire logic dout_oe_n_in,
  input wire phase_t phase_in,
  output logic cs_n_out,
  output logic sclk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  logic [63:0] cap;
  phase_t ph_log [1:64];
  int edge_cnt;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    last = 1'b0;
    cap = '0;
    edge_cnt = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick
  // mode 0: clock low at frame start, 1: clock high, 2: both fall together
  task automatic frame(input int mode, input int n);
    int k;
    logic pin;
    cap = '0;
    edge_cnt = 0;
    sclk_out <= (mode != 0);
    tick(4);
    cs_n_out <= 1'b0;
    if (mode == 2) sclk_out <= 1'b0;
    tick(4);
    for (k = 1; k <= n; k++) begin
      if (k > 1 || mode == 1) begin
        sclk_out <= 1'b0;
        tick(4);
      end
      // four system cycles per half period; sequencing does not depend on rate
      sclk_out <= 1'b1;
      pin = dout_oe_n_in ? ~last : dout_in;
      last = pin;
      cap = {cap[62:0], pin};
      ph_log[k] = phase_in;
      edge_cnt = k;
      tick(4);
    end
    cs_n_out <= 1'b1;
    tick(4);
    // clock halted while the frame is closed, to save power
    sclk_out <= 1'b0;
    tick(4);
  endtask : frame
endmodule : host_model
`default_nettype wire

// [tb/test_dual_adc_serial_readout.sv]
// Purpose: self-checking bench for the dual converter serial readout
// Assumes: host model frames every conversion, results come from sample_in
// Notes: each scenario judges the bits captured by the host model; test_single and test_continuous also judge its captured phases
`default_nettype none
module test_dual_adc_serial_readout
  import adc_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in;
  logic rst_n_in;
  logic cs_n;
  logic sclk;
  sample_pair_t sample_in;
  logic dout_out;
  logic dout_oe_n_out;
  phase_t phase_out;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  dual_adc_serial_readout dual_adc_serial_readout_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .sample_in(sample_in), .dout_out(dout_out), .dout_oe_n_out(dout_oe_n_out),
    .phase_out(phase_out));
  host_model host_model_inst (
    .clk_sys_in(clk_sys_in), .dout_in(dout_out), .dout_oe_n_in(dout_oe_n_out),
    .phase_in(phase_out), .cs_n_out(cs_n), .sclk_out(sclk));
  // ***************************************
  // shared helpers
  // ***************************************
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] group(input sample_pair_t s);
    return {4'h0, s.chan_a, 4'h0, s.chan_b};
  endfunction : group
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // ***************************************
  // scenarios
  // ***************************************
  task automatic test_single();
    sample_pair_t codes [3];
    logic [2:0] exp;
    int i;
    codes = '{'{12'h7FF, 12'h800}, '{12'h000, 12'hFFF}, '{12'h001, 12'hA5C}};
    for (i = 0; i < 3; i++) begin
      sample_in <= codes[i];
      host_model_inst.frame(0, 32);
      check("single bits", host_model_inst.cap[31:0], group(codes[i]));
      check("float after frame", dout_oe_n_out, 1'b1);
      check("rest after frame", phase_out, 3'b001);
    end
    for (i = 1; i <= 32; i++) begin
      exp = (i < 4) ? 3'b100 : (i < 16) ? 3'b010 : 3'b001;
      check("phase per edge", host_model_inst.ph_log[i], exp);
    end
    $display("test_single done");
  endtask : test_single
  task automatic test_clock_high();
    int m;
    sample_in <= '{12'h3C5, 12'hC3A};
    for (m = 1; m <= 2; m++) begin
      host_model_inst.frame(m, 32);
      check("late start bits", host_model_inst.cap[31:0], {4'h0, 12'h3C5, 4'h0, 12'hC3A});
    end
    $display("test_clock_high done");
  endtask : test_clock_high
  task automatic test_continuous();
    sample_pair_t s1;
    sample_pair_t s2;
    s1 = '{12'h123, 12'h456};
    s2 = '{12'hEDC, 12'hBA9};
    sample_in <= s1;
    fork
      host_model_inst.frame(0, 64);
      begin
        wait (host_model_inst.edge_cnt == 10);
        @(posedge clk_sys_in);
        sample_in <= s2;
      end
    join
    check("two groups", host_model_inst.cap, {group(s1), group(s2)});
    check("retrack", host_model_inst.ph_log[33], 3'b100);
    check("reconvert", host_model_inst.ph_log[36], 3'b010);
    $display("test_continuous done");
  endtask : test_continuous
  task automatic test_abort();
    sample_in <= '{12'h9E7, 12'h618};
    host_model_inst.frame(0, 8);
    check("partial bits", host_model_inst.cap[7:0], 8'h09);
    check("abort float", dout_oe_n_out, 1'b1);
    check("abort rest", phase_out, 3'b001);
    host_model_inst.frame(0, 32);
    check("fresh frame", host_model_inst.cap[31:0], {4'h0, 12'h9E7, 4'h0, 12'h618});
    $display("test_abort done");
  endtask : test_abort
  // ***************************************
  // main sequence and hang guard
  // ***************************************
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 12000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    sample_in = '0;
    repeat (15) @(posedge clk_sys_in);
    check("reset outputs", {dout_out, dout_oe_n_out, phase_out}, 5'b01001);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    test_single();
    test_clock_high();
    test_continuous();
    test_abort();
    finish_test();
  end
endmodule : test_dual_adc_serial_readout
`default_nettype wire
